/* File: hdl/clk_ctl_pkg.sv */
// Constants and types for the CPU clock selection and divider block
package clk_ctl_pkg;

   // ==========================================================
   // Register offsets (byte addresses on the bus)
   localparam logic [3:0] OFS_DIVIDE = 4'h0; // CPU clock divide value
   localparam logic [3:0] OFS_PORT2_MODE = 4'h4; // Port 2 mode register one
   localparam logic [3:0] OFS_STATUS = 4'h8; // Read-only state

   // ==========================================================
   // Field positions and reset values
   localparam int BIT_CLOCK_OUT_EN = 6; // Clock output enable bit
   localparam logic [7:0] DIVIDE_RESET = 8'h00; // Undivided after reset
   localparam logic [7:0] PORT2_MODE_RESET = 8'h00; // Clock out off

   // ==========================================================
   // Cycle counts
   localparam logic [2:0] MACHINE_CLOCKS = 3'h6; // CPU clocks per cycle
   localparam logic [1:0] CLKOUT_HALF_CLOCKS = 2'h3; // Half of 1/6 period
   localparam logic [10:0] WARM_XTAL_CLOCKS = 11'h400; // Crystal restart
   localparam logic [10:0] WARM_RC_CLOCKS = 11'h100; // RC or ext restart

   // ==========================================================
   // Oscillator source straps
   typedef enum logic [2:0] {
      SRC_XTAL_LOW = 3'b000,
      SRC_XTAL_MED = 3'b001,
      SRC_XTAL_HIGH = 3'b010,
      SRC_RC = 3'b011,
      SRC_EXT = 3'b100
   } osc_src_t;

   // Power state of the oscillator
   typedef enum logic [1:0] {
      PWR_RUN = 2'b00,
      PWR_DOWN = 2'b01,
      PWR_WARM = 2'b10
   } pwr_state_t;

   // Unknown codes count as crystal, so the pins stay safe
   function automatic logic is_crystal(input logic [2:0] src);
      is_crystal = (src != SRC_RC) && (src != SRC_EXT);
   endfunction

   // Restart count for the strapped source
   function automatic logic [10:0] warm_target(input logic [2:0] src);
      warm_target = is_crystal(src) ? WARM_XTAL_CLOCKS : WARM_RC_CLOCKS;
   endfunction

endpackage

/* File: hdl/cpu_clock_select_divide_out.sv */
// CPU clock selection, divider, clock output and oscillator pin sharing
// Notes on behaviour
// R1: Oscillator source fixed by straps, not software
// R2: External clock frees oscillator-output pin as port
// R3: Clock output only with RC or external clock
// R4: Enabled clock output drives pin, also in Idle
// R5: Clock output runs at CPU clock over six
// R6: Six CPU clocks per machine cycle; halving option
// R7: Halving also slows peripheral timing
// R8: Divide value resets zero; zero means undivided
// R9: Value N divides by two times N plus two
// R10: Divide value rewritable anytime without stalling
// R11: Fully static logic, correct down to stopped clock
// R12: Crystal source disables both oscillator pins
// R13: Wakeup waits 1024 or 256 clocks before running
// R14: New divisor taken only at divided boundary
`timescale 1ns/10ps
`default_nettype none

module cpu_clock_select_divide_out (
   input wire logic clk_in, // Oscillator, 20 MHz
   input wire logic srst_in, // Synchronous reset, active high
   // Avalon-MM slave
   input wire logic [3:0] avs_address_in, // Byte address
   input wire logic avs_read_in, // Read request
   input wire logic avs_write_in, // Write request
   input wire logic [31:0] avs_writedata_in, // Write data
   input wire logic [3:0] avs_byteenable_in, // Byte lanes
   output logic [31:0] avs_readdata_out, // Read data
   output logic avs_waitrequest_out, // Stall
   // Nonvolatile configuration straps
   input wire logic [2:0] osc_source_cfg_in, // Oscillator source type
   input wire logic classic_timing_halve_in, // Halve CPU clock
   // Power control from the CPU core
   input wire logic power_down_in, // Oscillator stop request
   // CPU side timing
   output logic cpu_clk_en_out, // CPU clock enable pulse
   output logic machine_cycle_en_out, // Machine cycle pulse
   output logic cpu_run_out, // Execution released
   // Oscillator-output pin, shared with port bit 0
   input wire logic osc_out_pin_in, // Pin level
   output logic osc_out_pin_o_out, // Pin drive value
   output logic osc_out_pin_oe_out, // Pin drive enable
   input wire logic osc_out_port_latch_in, // Port latch bit
   input wire logic osc_out_port_drive_in, // Port wants to drive
   output logic osc_out_port_value_out, // Pin seen by the port
   // Clock-input pin, shared with port bit 1
   input wire logic ext_clock_in_pin_in, // Pin level
   output logic ext_clock_pin_o_out, // Pin drive value
   output logic ext_clock_pin_oe_out, // Pin drive enable
   input wire logic ext_clock_port_latch_in, // Port latch bit
   input wire logic ext_clock_port_drive_in, // Port wants to drive
   output logic ext_clock_port_value_out // Pin seen by the port
);

   // ==========================================================
   // State
   typedef struct packed {
      logic x2_s1; // Pin synchroniser stages
      logic x2_s2;
      logic x1_s1;
      logic x1_s2;
      logic [2:0] osc_src; // Strapped source
      logic halve; // Strapped halving
      logic [7:0] cpu_clock_divide_value; // Divide value as written
      logic [7:0] cpu_clock_divide_value_act; // Divide value in use
      logic [7:0] p2mode; // Port 2 mode register one
      logic half_tog; // Halving phase
      logic [8:0] div_cnt; // Divider count
      logic cpu_en; // CPU clock enable
      logic mc_en; // Machine cycle enable
      logic [2:0] mc_cnt; // Position in machine cycle
      logic [1:0] co_cnt; // Clock out half-period count
      logic co_lvl; // Clock out level
      clk_ctl_pkg::pwr_state_t state; // Oscillator state
      logic [10:0] warm_cnt; // Restart count
      logic ack; // Bus answer cycle
      logic [31:0] rdata; // Read data
      logic x2_o; // Pin outputs, registered
      logic x2_oe;
      logic x2_val;
      logic x1_o;
      logic x1_oe;
      logic x1_val;
   } state_t;

   state_t q; // Registered state
   state_t d; // Next state

   logic req; // Any bus request
   logic osc_on; // Oscillator running
   logic pre_en; // Oscillator or halved enable
   logic cpu_en; // Divided CPU enable
   logic co_act; // Clock output allowed and enabled
   logic xtal; // Crystal source strapped

   assign req = avs_read_in | avs_write_in;
   assign xtal = clk_ctl_pkg::is_crystal(q.osc_src);
   assign osc_on = (q.state != clk_ctl_pkg::PWR_DOWN);
   // Clock output needs a non-crystal source and the enable bit
   assign co_act = q.p2mode[clk_ctl_pkg::BIT_CLOCK_OUT_EN] && !xtal; // see R3

   // ==========================================================
   // Next-state logic
   // The whole block advances only on oscillator edges and holds
   // no dynamic nodes, so a stopped input clock loses nothing.
   always_comb begin // see R11
      d = q;
      d.ack = 1'b0;
      pre_en = 1'b0;
      cpu_en = 1'b0;

      // Pin synchronisers; second stage is the only reader
      d.x2_s1 = osc_out_pin_in;
      d.x2_s2 = q.x2_s1;
      d.x1_s1 = ext_clock_in_pin_in;
      d.x1_s2 = q.x1_s1;

      // Halving stage, applied ahead of everything timed
      if (osc_on) begin
         d.half_tog = ~q.half_tog;
         pre_en = q.halve ? q.half_tog : 1'b1; // see R6, R7
      end

      // Programmable divider: 2N+2 pre pulses, N zero passes through
      if (pre_en) begin
         if (q.cpu_clock_divide_value_act == 8'h00) begin
            cpu_en = 1'b1; // see R8
            d.div_cnt = 9'h000;
            d.cpu_clock_divide_value_act = q.cpu_clock_divide_value; // see R14
         end else if (q.div_cnt == {q.cpu_clock_divide_value_act, 1'b1}) begin
            cpu_en = 1'b1; // see R9
            d.div_cnt = 9'h000;
            d.cpu_clock_divide_value_act = q.cpu_clock_divide_value; // see R14
         end else begin
            d.div_cnt = q.div_cnt + 9'h001;
         end
      end
      d.cpu_en = cpu_en;
      d.mc_en = 1'b0;

      // Machine cycle and clock output both count CPU clocks
      if (cpu_en) begin
         if (q.mc_cnt == clk_ctl_pkg::MACHINE_CLOCKS - 3'h1) begin
            d.mc_cnt = 3'h0;
            d.mc_en = 1'b1; // see R6
         end else begin
            d.mc_cnt = q.mc_cnt + 3'h1;
         end
         if (q.co_cnt == clk_ctl_pkg::CLKOUT_HALF_CLOCKS - 2'h1) begin
            d.co_cnt = 2'h0;
            d.co_lvl = ~q.co_lvl; // see R5
         end else begin
            d.co_cnt = q.co_cnt + 2'h1;
         end
      end

      // Oscillator stop and restart sequencing
      case (q.state)
         clk_ctl_pkg::PWR_RUN: begin
            if (power_down_in) begin
               d.state = clk_ctl_pkg::PWR_DOWN;
            end
         end
         clk_ctl_pkg::PWR_DOWN: begin
            // Oscillator off; no enables are produced here
            if (!power_down_in) begin
               d.state = clk_ctl_pkg::PWR_WARM;
               d.warm_cnt = 11'h000;
            end
         end
         clk_ctl_pkg::PWR_WARM: begin
            // Execution held until the source has settled
            if (cpu_en) begin
               if (q.warm_cnt ==
                   clk_ctl_pkg::warm_target(q.osc_src) - 11'h001) begin
                  d.state = clk_ctl_pkg::PWR_RUN; // see R13
               end else begin
                  d.warm_cnt = q.warm_cnt + 11'h001;
               end
            end
         end
         default: begin
            d.state = clk_ctl_pkg::PWR_RUN;
         end
      endcase

      // Oscillator-output pin: crystal, clock out, or port bit
      if (xtal) begin
         d.x2_oe = 1'b0; // see R12
         d.x2_o = 1'b0;
         d.x2_val = 1'b0;
      end else if (co_act) begin
         d.x2_oe = 1'b1; // see R4
         d.x2_o = q.co_lvl;
         d.x2_val = q.x2_s2;
      end else begin
         d.x2_oe = osc_out_port_drive_in; // see R2
         d.x2_o = osc_out_port_latch_in;
         d.x2_val = q.x2_s2;
      end

      // Clock-input pin: only the RC source leaves it to the port
      if (q.osc_src == clk_ctl_pkg::SRC_RC) begin
         d.x1_oe = ext_clock_port_drive_in;
         d.x1_o = ext_clock_port_latch_in;
         d.x1_val = q.x1_s2;
      end else begin
         d.x1_oe = 1'b0; // see R12
         d.x1_o = 1'b0;
         d.x1_val = 1'b0;
      end

      // Bus: first edge latches read data, second edge answers.
      // Writes land on the answer edge; the divider keeps running.
      if (req && !q.ack) begin
         d.ack = 1'b1;
         case (avs_address_in)
            clk_ctl_pkg::OFS_DIVIDE: begin
               d.rdata = {24'h000000, q.cpu_clock_divide_value};
            end
            clk_ctl_pkg::OFS_PORT2_MODE: begin
               d.rdata = {24'h000000, q.p2mode};
            end
            clk_ctl_pkg::OFS_STATUS: begin
               d.rdata = {16'h0000, q.cpu_clock_divide_value_act, 2'h0, co_act,
                          (q.state == clk_ctl_pkg::PWR_RUN), q.halve,
                          q.osc_src};
            end
            default: begin
               d.rdata = 32'h00000000; // Unmapped reads zero
            end
         endcase
      end
      if (avs_write_in && q.ack && avs_byteenable_in[0]) begin
         case (avs_address_in)
            clk_ctl_pkg::OFS_DIVIDE: begin
               d.cpu_clock_divide_value = avs_writedata_in[7:0]; // see R10
            end
            clk_ctl_pkg::OFS_PORT2_MODE: begin
               d.p2mode = avs_writedata_in[7:0];
            end
            default: begin
               // Straps and status are not writable
               d.cpu_clock_divide_value = q.cpu_clock_divide_value; // see R1
            end
         endcase
      end
   end

   // ==========================================================
   // Register stage; straps are sampled on every reset edge
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         q <= '0;
         q.cpu_clock_divide_value <= clk_ctl_pkg::DIVIDE_RESET; // see R8
         q.cpu_clock_divide_value_act <= clk_ctl_pkg::DIVIDE_RESET;
         q.p2mode <= clk_ctl_pkg::PORT2_MODE_RESET;
         q.state <= clk_ctl_pkg::PWR_RUN;
         q.osc_src <= osc_source_cfg_in; // see R1
         q.halve <= classic_timing_halve_in;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   assign avs_waitrequest_out = req && !q.ack;
   assign avs_readdata_out = q.rdata;
   assign cpu_clk_en_out = q.cpu_en;
   assign machine_cycle_en_out = q.mc_en;
   assign cpu_run_out = (q.state == clk_ctl_pkg::PWR_RUN);
   assign osc_out_pin_o_out = q.x2_o;
   assign osc_out_pin_oe_out = q.x2_oe;
   assign osc_out_port_value_out = q.x2_val;
   assign ext_clock_pin_o_out = q.x1_o;
   assign ext_clock_pin_oe_out = q.x1_oe;
   assign ext_clock_port_value_out = q.x1_val;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);

   a_cfg_fixed: assert property ( // see R1
      1'b1 |=> $stable(q.osc_src) && $stable(q.halve))
      else $error("Strapped configuration changed");

   a_port_release: assert property ( // see R2
      q.osc_src == clk_ctl_pkg::SRC_EXT && !co_act && !srst_in
      |=> osc_out_pin_oe_out == $past(osc_out_port_drive_in))
      else $error("Port bit not released with external clock");

   a_xtal_no_out: assert property ( // see R3
      xtal |=> !osc_out_pin_oe_out && !osc_out_port_value_out)
      else $error("Oscillator-output pin active with crystal");

   a_clkout_drive: assert property ( // see R4
      co_act |=> osc_out_pin_oe_out && osc_out_pin_o_out == $past(q.co_lvl))
      else $error("Clock output not driven");

   a_clkout_step: assert property ( // see R5
      $changed(q.co_lvl) |-> q.cpu_en && q.co_cnt == 2'h0)
      else $error("Clock output toggled off a CPU clock boundary");

   a_machine_six: assert property ( // see R6
      machine_cycle_en_out |-> cpu_clk_en_out ##1
      (!machine_cycle_en_out) [*5])
      else $error("Machine cycle shorter than six CPU clocks");

   a_halve_gap: assert property ( // see R7
      q.halve && cpu_clk_en_out |=> !cpu_clk_en_out)
      else $error("Halved clock produced adjacent enables");

   a_zero_pass: assert property ( // see R8
      q.cpu_clock_divide_value_act == 8'h00 && !q.halve && osc_on && !srst_in |=> cpu_clk_en_out)
      else $error("Undivided clock missed an enable");

   a_div_four: assert property ( // see R9
      cpu_clk_en_out && q.cpu_clock_divide_value_act == 8'h01 && !q.halve &&
      q.state == clk_ctl_pkg::PWR_RUN && !power_down_in
      |=> (!cpu_clk_en_out) [*3])
      else $error("Divide by four period too short");

   a_div_boundary: assert property ( // see R14
      $changed(q.cpu_clock_divide_value_act) |-> q.cpu_en)
      else $error("Divisor taken mid period");

   a_xtal_pin1: assert property ( // see R12
      xtal |=> !ext_clock_pin_oe_out && !ext_clock_port_value_out)
      else $error("Clock-input pin active with crystal");

   a_warm_count: assert property ( // see R13
      $rose(cpu_run_out) |-> $past(q.warm_cnt) ==
      clk_ctl_pkg::warm_target(q.osc_src) - 11'h001)
      else $error("Execution released before restart count");

endmodule

`default_nettype wire

/* File: tb/ext_clock_source.sv */
// Far-side model: external clock source and resolution of the two pins
`timescale 1ns/10ps
`default_nettype none

module ext_clock_source (
   input wire logic clk_in, // Bench clock
   input wire logic stop_in, // Hold the source still
   input wire logic osc_o_in, // Block drive, oscillator-output pin
   input wire logic osc_oe_in, // Block enable, oscillator-output pin
   input wire logic ext_o_in, // Block drive, clock-input pin
   input wire logic ext_oe_in, // Block enable, clock-input pin
   output logic osc_pin_out, // Resolved oscillator-output pin
   output logic ext_pin_out // Resolved clock-input pin
);
   // ==========================================================
   // Source state
   logic src_q = 1'b0; // Source level on the clock-input pin
   logic float_q = 1'b0; // Pattern of an undriven pin

   // Source may stop at any time, so the block must be static
   always_ff @(posedge clk_in) begin
      if (!stop_in) begin
         src_q <= ~src_q;
      end
      float_q <= ~osc_pin_out;
   end

   // Undriven oscillator-output pin flips every cycle so a stale value never passes
   assign osc_pin_out = osc_oe_in ? osc_o_in : float_q;
   assign ext_pin_out = ext_oe_in ? ext_o_in : src_q;
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the CPU clock selection and divider block
`timescale 1ns/10ps
`default_nettype none

module testbench;
   // ==========================================================
   // Stimulus and observed signals
   logic clk_in = 1'b0; // 20 MHz clock
   logic srst_in = 1'b1; // Held in reset at start
   logic [3:0] avs_address_in = 4'h0;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic [2:0] osc_source_cfg_in = 3'h3; // RC strap by default
   logic classic_timing_halve_in = 1'b0;
   logic power_down_in = 1'b0;
   logic cpu_clk_en_out, machine_cycle_en_out, cpu_run_out;
   logic osc_pin, osc_o, osc_oe, osc_latch = 1'b0, osc_drive = 1'b0;
   logic osc_value, ext_pin, ext_o, ext_oe, ext_value;
   logic ext_latch = 1'b0, ext_drive = 1'b0, stop = 1'b0;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;

   always #25 clk_in = ~clk_in;

   cpu_clock_select_divide_out i_dut (
      .clk_in(clk_in), .srst_in(srst_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(4'h1), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out),
      .osc_source_cfg_in(osc_source_cfg_in),
      .classic_timing_halve_in(classic_timing_halve_in),
      .power_down_in(power_down_in), .cpu_clk_en_out(cpu_clk_en_out),
      .machine_cycle_en_out(machine_cycle_en_out),
      .cpu_run_out(cpu_run_out), .osc_out_pin_in(osc_pin),
      .osc_out_pin_o_out(osc_o), .osc_out_pin_oe_out(osc_oe),
      .osc_out_port_latch_in(osc_latch),
      .osc_out_port_drive_in(osc_drive),
      .osc_out_port_value_out(osc_value), .ext_clock_in_pin_in(ext_pin),
      .ext_clock_pin_o_out(ext_o), .ext_clock_pin_oe_out(ext_oe),
      .ext_clock_port_latch_in(ext_latch),
      .ext_clock_port_drive_in(ext_drive),
      .ext_clock_port_value_out(ext_value)
   );

   ext_clock_source i_src (
      .clk_in(clk_in), .stop_in(stop), .osc_o_in(osc_o),
      .osc_oe_in(osc_oe), .ext_o_in(ext_o), .ext_oe_in(ext_oe),
      .osc_pin_out(osc_pin), .ext_pin_out(ext_pin)
   );

   // ==========================================================
   // Shared tasks
   task automatic summarize();
      $display("errors %0d, compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Avalon-MM access held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [7:0] d, output logic [31:0] q);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= {24'h0, d};
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      // Only the cycle ceiling ends a wait that never answers
      do begin
         @(posedge clk_in);
      end while (avs_waitrequest_out !== 1'b0);
      // Read data taken at the completing edge, then released
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask

   task automatic do_reset(input logic [2:0] src, input logic h);
      @(posedge clk_in);
      osc_source_cfg_in <= src;
      classic_timing_halve_in <= h;
      srst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      srst_in <= 1'b0;
   endtask

   // Cycles between two pulses of the CPU or machine enable
   task automatic gap(input logic mc, output int g);
      int n;
      n = 0;
      g = 0;
      @(negedge clk_in);
      while ((mc ? machine_cycle_en_out : cpu_clk_en_out) !== 1'b1
             && n < 2000) begin
         n++;
         @(negedge clk_in);
      end
      do begin
         @(negedge clk_in);
         g++;
      end while ((mc ? machine_cycle_en_out : cpu_clk_en_out) !== 1'b1
                 && g < 2000);
   endtask

   // Cycles between two level changes of the clock output
   task automatic half_period(output int g);
      logic v;
      v = osc_o;
      g = 0;
      while (osc_o === v && g < 200) begin
         @(negedge clk_in);
         g++;
      end
      v = osc_o;
      g = 0;
      while (osc_o === v && g < 200) begin
         @(negedge clk_in);
         g++;
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_regs();
      logic [31:0] q;
      do_reset(3'h3, 1'b0);
      bus(1'b0, 4'h0, 8'h00, q);
      check(q, 32'h0);
      bus(1'b0, 4'hc, 8'h00, q);
      check(q, 32'h0);
      bus(1'b1, 4'h8, 8'hff, q);
      bus(1'b0, 4'h8, 8'h00, q);
      check({28'h0, q[3:0]}, 32'h3);
   endtask

   task automatic t_div();
      logic [31:0] q;
      logic [7:0] vals [4] = '{8'h01, 8'h02, 8'hff, 8'h00};
      int g;
      do_reset(3'h3, 1'b0);
      gap(1'b0, g);
      check(g, 1);
      gap(1'b1, g);
      check(g, 6);
      foreach (vals[i]) begin
         bus(1'b1, 4'h0, vals[i], q);
         gap(1'b0, g);
         gap(1'b0, g);
         check(g, vals[i] == 8'h0 ? 1 : 2 * (vals[i] + 1));
      end
   endtask

   task automatic t_halve();
      int g;
      do_reset(3'h3, 1'b1);
      gap(1'b0, g);
      check(g, 2);
      gap(1'b1, g);
      check(g, 12);
   endtask

   task automatic t_clkout(input logic [2:0] src, input logic on);
      logic [31:0] q;
      int g;
      do_reset(src, 1'b0);
      osc_drive <= 1'b1;
      ext_drive <= 1'b1;
      osc_latch <= 1'b1;
      ext_latch <= 1'b1;
      bus(1'b1, 4'h4, 8'h40, q);
      bus(1'b1, 4'h0, 8'h01, q);
      repeat (30) @(negedge clk_in);
      check(osc_oe, on);
      if (src == 3'h3) begin
         // RC source leaves the clock-input pin to the port
         check({ext_oe, ext_o, ext_value}, 3'h7);
      end
      if (on) begin
         half_period(g);
         check(g, 12);
      end else begin
         check({ext_oe, osc_value, ext_value}, 3'h0);
      end
      @(posedge clk_in);
      osc_drive <= 1'b0;
      ext_drive <= 1'b0;
   endtask

   task automatic t_port();
      do_reset(3'h4, 1'b0);
      osc_drive <= 1'b1;
      osc_latch <= 1'b1;
      repeat (6) @(negedge clk_in);
      check({osc_oe, osc_o, osc_value}, 3'h7);
      @(posedge clk_in);
      osc_latch <= 1'b0;
      repeat (6) @(negedge clk_in);
      check({osc_oe, osc_o, osc_value}, 3'h4);
      @(posedge clk_in);
      osc_drive <= 1'b0;
   endtask

   task automatic t_wake(input int lo);
      int n;
      n = 0;
      @(posedge clk_in);
      power_down_in <= 1'b1;
      stop <= 1'b1;
      repeat (4) @(negedge clk_in);
      check(cpu_run_out, 1'b0);
      @(posedge clk_in);
      power_down_in <= 1'b0;
      stop <= 1'b0;
      while (cpu_run_out !== 1'b1 && n < 3000) begin
         @(negedge clk_in);
         n++;
      end
      check(n >= lo && n <= lo + 8, 1'b1);
   endtask

   // ==========================================================
   // Cycle ceiling cuts a hang short
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_errors++;
         summarize();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_in);
      srst_in <= 1'b0;
      t_regs();
      t_div();
      t_halve();
      t_clkout(3'h3, 1'b1);
      t_clkout(3'h4, 1'b1);
      do_reset(3'h3, 1'b0);
      t_wake(256);
      t_port();
      t_clkout(3'h0, 1'b0);
      do_reset(3'h0, 1'b0);
      t_wake(1024);
      summarize();
   end
endmodule

`default_nettype wire
